/* File: rtl/rsw_top.sv */
// rsw_top: reset supervisor with watchdog, voltage reset and voltage detector.
// assumes the core drives an 8-bit register port and supplies the operating mode;
// comparator results and the power-on level arrive from analogue cells off-clock.
`timescale 1ns/1ps
module rsw_top #(
    parameter int WARMUP_CYCLES = rsw_pkg::WARMUP_CYCLES,
    parameter int ADDR_W        = 14,
    parameter logic [ADDR_W-1:0] CFG_BASE = ADDR_W'(14'h3ff8)
) (
    input  wire logic               core_clk,     // 200 MHz core clock
    input  wire logic               reset,        // power-on, async, high
    input  wire rsw_pkg::rsw_sfr_req_s sfr_req,   // register access from core
    output logic [7:0]              sfr_rdata,    // register read data
    output logic                    sfr_hit,      // address belongs to this block
    input  wire rsw_pkg::rsw_mode_e op_mode,      // current operating mode
    input  wire logic               ext_rst_n,    // external reset pin, low active
    input  wire logic               detect_cmp,   // detector comparator out, async
    input  wire logic               vreset_cmp,   // supply below reset level, async
    output logic [ADDR_W-1:0]       rom_addr,     // program memory address
    output logic                    rom_rd,       // program memory read strobe
    input  wire logic [7:0]         rom_data,     // program memory data, next cycle
    output rsw_pkg::rsw_analog_s    analog_ctl,   // analogue enables and levels
    output logic                    sys_rst,      // chip reset, high
    output logic [7:0]              config_word_high // loaded configuration byte
);

    // ****************************************
    // state and declarations
    // ****************************************
    typedef enum logic [1:0] {
        RSW_ST_WARM,
        RSW_ST_LOAD,
        RSW_ST_RUN
    } rsw_state_e;

    localparam int WARM_W = $clog2(WARMUP_CYCLES + 1);
    localparam int DIV_W  = $clog2(rsw_pkg::SLOW_DIV_CYCLES + 1);

    rsw_state_e         state_r;
    logic [WARM_W-1:0]  warm_cnt_r;
    logic [3:0]         load_idx_r;
    logic               rd_pend_r;
    logic [DIV_W-1:0]   div_cnt_r;
    logic               slow_tick;
    logic               pin_n_s;
    logic               det_s;
    logic               vr_s;
    logic [1:0]         pin_low_cnt_r;
    logic               pin_rst_r;
    logic               sw_rst_r;
    logic               wdt_ovf;
    logic               wdt_rst_r;
    logic               vr_rst_r;
    logic               src_any;
    logic [1:0]         rel_r;
    logic [7:0]         option_r;
    logic [7:0]         auxiliary_ctrl_two_r;
    logic               wdt_clr_r;
    logic [6:0]         auxiliary_ctrl_one_rest_r;
    logic [7:0]         vrctl_r;
    logic [7:0]         detctl_r;
    logic               det_flag_r;
    logic [6:0]         intflag_rest_r;
    logic               awake;
    logic               asleep_deep;
    logic               vreset_on;
    logic               wdt_run;
    logic               flag_cond;

    function automatic logic is_wr(input rsw_pkg::rsw_sfr_req_s r, input logic [7:0] a);
        is_wr = r.wr && (r.addr == a);
    endfunction : is_wr

    // ****************************************
    // pin and comparator synchronisers
    // ****************************************
    rsw_sync #(.RESET_VAL(1'b1)) u_pin_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in (ext_rst_n),
        .sync_out (pin_n_s)
    );

    rsw_sync #(.RESET_VAL(1'b0)) u_det_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in (detect_cmp),
        .sync_out (det_s)
    );

    rsw_sync #(.RESET_VAL(1'b0)) u_vr_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in (vreset_cmp),
        .sync_out (vr_s)
    );

    // ****************************************
    // slow oscillator time base
    // ****************************************
    // the slow oscillator is modelled as an enable from the core clock
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            div_cnt_r <= '0;
        end else if (div_cnt_r == DIV_W'(rsw_pkg::SLOW_DIV_CYCLES - 1)) begin
            div_cnt_r <= '0;
        end else begin
            div_cnt_r <= div_cnt_r + DIV_W'(1);
        end
    end
    assign slow_tick = (div_cnt_r == DIV_W'(rsw_pkg::SLOW_DIV_CYCLES - 1));

    // ****************************************
    // power-up warm-up and configuration load
    // ****************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_r          <= RSW_ST_WARM;
            warm_cnt_r       <= '0;
            load_idx_r       <= '0;
            rd_pend_r        <= 1'b0;
            config_word_high <= rsw_pkg::RST_CFGW;
        end else begin
            case (state_r)
                RSW_ST_WARM: begin
                    if (warm_cnt_r == WARM_W'(WARMUP_CYCLES - 1)) begin
                        state_r <= RSW_ST_LOAD;
                    end else begin
                        warm_cnt_r <= warm_cnt_r + WARM_W'(1);
                    end
                end
                RSW_ST_LOAD: begin
                    // reads all eight bytes; the high configuration byte is the last
                    rd_pend_r <= (load_idx_r < 4'(rsw_pkg::CFG_LOAD_BYTES));
                    if (load_idx_r < 4'(rsw_pkg::CFG_LOAD_BYTES)) begin
                        load_idx_r <= load_idx_r + 4'h1;
                    end
                    if (rd_pend_r && load_idx_r == 4'(rsw_pkg::CFG_LOAD_BYTES)) begin
                        config_word_high <= rom_data;
                    end
                    if (!rd_pend_r && load_idx_r == 4'(rsw_pkg::CFG_LOAD_BYTES)) begin
                        state_r <= RSW_ST_RUN;
                    end
                end
                RSW_ST_RUN: begin
                    state_r <= RSW_ST_RUN;
                end
                default: begin
                    state_r <= RSW_ST_WARM;
                end
            endcase
        end
    end
    assign rom_rd   = (state_r == RSW_ST_LOAD) && (load_idx_r < 4'(rsw_pkg::CFG_LOAD_BYTES));
    assign rom_addr = CFG_BASE + ADDR_W'(load_idx_r);

    // ****************************************
    // reset sources
    // ****************************************
    // pin must be seen low on two slow ticks in a row; shorter glitches are ignored
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pin_low_cnt_r <= '0;
            pin_rst_r     <= 1'b0;
        end else if (pin_n_s) begin
            pin_low_cnt_r <= '0;
            pin_rst_r     <= 1'b0;
        end else if (slow_tick) begin
            if (pin_low_cnt_r >= 2'(rsw_pkg::PIN_LOW_SLOW_TICKS - 1)) begin
                pin_rst_r <= config_word_high[rsw_pkg::CFG_PIN_EN_BIT];
            end else begin
                pin_low_cnt_r <= pin_low_cnt_r + 2'h1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sw_rst_r <= 1'b0;
        end else begin
            sw_rst_r <= is_wr(sfr_req, rsw_pkg::ADDR_SOFTWARE_COMMAND)
                        && (sfr_req.wdata == rsw_pkg::SW_RESET_KEY);
        end
    end

    assign awake       = (op_mode == rsw_pkg::RSW_MODE_FAST) || (op_mode == rsw_pkg::RSW_MODE_SLOW);
    assign asleep_deep = (op_mode == rsw_pkg::RSW_MODE_HALT) || (op_mode == rsw_pkg::RSW_MODE_STOP);

    always_comb begin
        case (auxiliary_ctrl_two_r[rsw_pkg::WDT_EN_LO +: 2])
            2'b10:   wdt_run = awake;
            2'b11:   wdt_run = 1'b1;
            default: wdt_run = 1'b0;
        endcase
    end

    rsw_wdt #(.CNT_W(16)) u_wdt (
        .core_clk  (core_clk),
        .reset     (reset),
        .sys_rst   (sys_rst),
        .slow_tick (slow_tick),
        .run       (wdt_run),
        .clear     (wdt_clr_r),
        .prescale  (option_r[rsw_pkg::WDT_PSC_LO +: 2]),
        .overflow  (wdt_ovf)
    );

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wdt_rst_r <= 1'b0;
        end else begin
            wdt_rst_r <= wdt_ovf;
        end
    end

    // voltage reset is gated by its disable bit and by power saving in sleep modes
    assign vreset_on = !vrctl_r[rsw_pkg::VR_DIS_BIT]
                       && !(auxiliary_ctrl_two_r[rsw_pkg::POWER_SAVING_OPTION_BIT] && !awake);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            vr_rst_r <= 1'b0;
        end else begin
            vr_rst_r <= vreset_on && vr_s;
        end
    end

    // ****************************************
    // merged system reset
    // ****************************************
    // asserted one clock after a source rises, released two clocks after the last source drops
    assign src_any = (state_r != RSW_ST_RUN) || pin_rst_r || sw_rst_r
                     || wdt_rst_r || vr_rst_r;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rel_r <= 2'b11;
        end else if (src_any) begin
            rel_r <= 2'b11;
        end else begin
            rel_r <= {rel_r[0], 1'b0};
        end
    end
    assign sys_rst = rel_r[1];

    // ****************************************
    // special-function registers
    // ****************************************
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            option_r <= rsw_pkg::RST_OPTION;
            auxiliary_ctrl_two_r   <= rsw_pkg::RST_AUXILIARY_CTRL_TWO;
            vrctl_r  <= rsw_pkg::RST_VRCTL;
        end else if (sys_rst) begin
            option_r <= rsw_pkg::RST_OPTION;
            auxiliary_ctrl_two_r   <= rsw_pkg::RST_AUXILIARY_CTRL_TWO;
            vrctl_r  <= rsw_pkg::RST_VRCTL;
        end else begin
            if (is_wr(sfr_req, rsw_pkg::ADDR_OPTION)) begin
                option_r <= sfr_req.wdata & 8'h7c;
            end
            if (is_wr(sfr_req, rsw_pkg::ADDR_AUXILIARY_CTRL_TWO)) begin
                auxiliary_ctrl_two_r <= sfr_req.wdata;
            end
            if (is_wr(sfr_req, rsw_pkg::ADDR_VRCTL)) begin
                vrctl_r <= sfr_req.wdata & 8'h7f;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wdt_clr_r   <= 1'b0;
            auxiliary_ctrl_one_rest_r <= rsw_pkg::RST_AUXILIARY_CTRL_ONE[6:0];
        end else if (sys_rst) begin
            wdt_clr_r   <= 1'b0;
            auxiliary_ctrl_one_rest_r <= rsw_pkg::RST_AUXILIARY_CTRL_ONE[6:0];
        end else if (is_wr(sfr_req, rsw_pkg::ADDR_AUXILIARY_CTRL_ONE)) begin
            wdt_clr_r   <= sfr_req.wdata[rsw_pkg::WDT_CLR_BIT];
            auxiliary_ctrl_one_rest_r <= sfr_req.wdata[6:0];
        end else begin
            wdt_clr_r   <= 1'b0;
        end
    end

    // detect threshold default comes from the loaded configuration byte
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            detctl_r <= rsw_pkg::RST_DETCTL;
        end else if (sys_rst) begin
            detctl_r <= {4'h0, config_word_high[4:1]};
        end else if (is_wr(sfr_req, rsw_pkg::ADDR_DETCTL)) begin
            detctl_r <= sfr_req.wdata & 8'h9f;
        end
    end

    assign flag_cond = analog_ctl.detector_on
                       && (det_s != detctl_r[rsw_pkg::DET_POL_BIT]);

    // set wins over a clearing write in the same cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            det_flag_r     <= 1'b0;
            intflag_rest_r <= rsw_pkg::RST_INTFLAG[6:0];
        end else if (sys_rst) begin
            det_flag_r     <= 1'b0;
            intflag_rest_r <= rsw_pkg::RST_INTFLAG[6:0];
        end else begin
            if (flag_cond) begin
                det_flag_r <= 1'b1;
            end else if (is_wr(sfr_req, rsw_pkg::ADDR_INTFLAG)
                         && !sfr_req.wdata[rsw_pkg::DET_FLAG_BIT]) begin
                det_flag_r <= 1'b0;
            end
            if (is_wr(sfr_req, rsw_pkg::ADDR_INTFLAG)) begin
                intflag_rest_r <= intflag_rest_r & sfr_req.wdata[6:0];
            end
        end
    end

    // ****************************************
    // analogue controls
    // ****************************************
    always_comb begin
        analog_ctl.vreset_on            = vreset_on;
        analog_ctl.reset_threshold_sel  = vrctl_r[3:0];
        if (asleep_deep && !config_word_high[rsw_pkg::CFG_SLP_EN_BIT]) begin
            analog_ctl.powerup_reset_on = !vrctl_r[rsw_pkg::POR_SLP_BIT];
        end else begin
            analog_ctl.powerup_reset_on = !vrctl_r[rsw_pkg::POR_DIS_BIT];
        end
        analog_ctl.detector_on          = awake && !detctl_r[rsw_pkg::DET_DIS_BIT];
        analog_ctl.detect_threshold_sel = detctl_r[3:0];
    end

    // ****************************************
    // read-back
    // ****************************************
    always_comb begin
        sfr_hit = 1'b1;
        case (sfr_req.addr)
            rsw_pkg::ADDR_OPTION:  sfr_rdata = option_r;
            rsw_pkg::ADDR_INTFLAG: sfr_rdata = {det_flag_r, intflag_rest_r};
            rsw_pkg::ADDR_DETCTL:  sfr_rdata = {detctl_r[7], det_s, detctl_r[5:0]};
            rsw_pkg::ADDR_VRCTL:   sfr_rdata = vrctl_r;
            rsw_pkg::ADDR_AUXILIARY_CTRL_TWO:    sfr_rdata = auxiliary_ctrl_two_r;
            rsw_pkg::ADDR_AUXILIARY_CTRL_ONE:    sfr_rdata = {wdt_clr_r, auxiliary_ctrl_one_rest_r};
            default: begin
                sfr_rdata = 8'h00;
                sfr_hit   = (sfr_req.addr == rsw_pkg::ADDR_SOFTWARE_COMMAND);
            end
        endcase
    end

endmodule : rsw_top

/* File: rtl/rsw_pkg.sv */
// rsw_pkg: register offsets, field positions, reset values and timing constants
// of the reset supervisor and watchdog block.
// assumes a 200 MHz core clock and an 8-bit special-function register port.
package rsw_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int  CORE_CLK_MHZ        = 200;
    localparam int  WARMUP_MS           = 40;
    localparam int  WARMUP_CYCLES       = WARMUP_MS * 1000 * CORE_CLK_MHZ;
    localparam int  SLOW_RC_HZ          = 75000;
    localparam int  SLOW_DIV_CYCLES     = (CORE_CLK_MHZ * 1000000) / SLOW_RC_HZ;
    localparam int  PIN_LOW_SLOW_TICKS  = 2;
    localparam int  WDT_MS_00           = 220;
    localparam int  WDT_MS_01           = 110;
    localparam int  WDT_MS_10           = 55;
    localparam int  WDT_MS_11           = 27;
    localparam int  CFG_LOAD_BYTES      = 8;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] ADDR_OPTION  = 8'h94;
    localparam logic [7:0] ADDR_INTFLAG = 8'h95;
    localparam logic [7:0] ADDR_SOFTWARE_COMMAND   = 8'h97;
    localparam logic [7:0] ADDR_DETCTL  = 8'hbf;
    localparam logic [7:0] ADDR_VRCTL   = 8'he3;
    localparam logic [7:0] ADDR_AUXILIARY_CTRL_TWO    = 8'hf7;
    localparam logic [7:0] ADDR_AUXILIARY_CTRL_ONE    = 8'hf8;

    localparam logic [7:0] SW_RESET_KEY = 8'h56;

    // ****************************************
    // field positions
    // ****************************************
    localparam int  WDT_PSC_LO          = 4;
    localparam int  WDT_EN_LO           = 6;
    localparam int  POWER_SAVING_OPTION_BIT          = 5;
    localparam int  WDT_CLR_BIT         = 7;
    localparam int  DET_FLAG_BIT        = 7;
    localparam int  DET_POL_BIT         = 7;
    localparam int  DET_OUT_BIT         = 6;
    localparam int  DET_DIS_BIT         = 4;
    localparam int  VR_DIS_BIT          = 4;
    localparam int  POR_DIS_BIT         = 5;
    localparam int  POR_SLP_BIT         = 6;
    localparam int  CFG_SLP_EN_BIT      = 5;
    localparam int  CFG_PIN_EN_BIT      = 7;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_OPTION   = 8'h00;
    localparam logic [7:0] RST_INTFLAG  = 8'h00;
    localparam logic [7:0] RST_VRCTL    = 8'h40;
    localparam logic [7:0] RST_AUXILIARY_CTRL_TWO     = 8'h00;
    localparam logic [7:0] RST_AUXILIARY_CTRL_ONE     = 8'h28;
    localparam logic [7:0] RST_DETCTL   = 8'h00;
    localparam logic [7:0] RST_CFGW     = 8'h00;

    typedef enum logic [2:0] {
        RSW_MODE_FAST,
        RSW_MODE_SLOW,
        RSW_MODE_IDLE,
        RSW_MODE_HALT,
        RSW_MODE_STOP
    } rsw_mode_e;

    // analogue controls leaving the block
    typedef struct packed {
        logic       vreset_on;
        logic [3:0] reset_threshold_sel;
        logic       powerup_reset_on;
        logic       detector_on;
        logic [3:0] detect_threshold_sel;
    } rsw_analog_s;

    // special-function register access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rsw_sfr_req_s;

endpackage : rsw_pkg

/* File: rtl/rsw_sync.sv */
// rsw_sync: two-stage synchroniser for single-bit levels from outside the clock.
// assumes the input is a slow level; pulses shorter than one clock may be lost.
`timescale 1ns/1ps
module rsw_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic core_clk,  // core clock
    input  wire logic reset,     // async reset, high
    input  wire logic async_in,  // level from outside
    output logic      sync_out   // synchronised level
);
    logic meta_r;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            meta_r   <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : rsw_sync

/* File: rtl/rsw_wdt.sv */
// rsw_wdt: watchdog counter ticking on slow-oscillator enables.
// assumes slow_tick is a one-cycle pulse at the slow oscillator rate.
`timescale 1ns/1ps
module rsw_wdt #(
    parameter int CNT_W = 16
) (
    input  wire logic       core_clk,    // core clock
    input  wire logic       reset,       // async reset, high
    input  wire logic       sys_rst,     // system reset, clears count
    input  wire logic       slow_tick,   // slow oscillator enable
    input  wire logic       run,         // counting allowed
    input  wire logic       clear,       // software clear pulse
    input  wire logic [1:0] prescale,    // period select
    output logic            overflow     // one-cycle overflow pulse
);
    localparam int SLOW_KHZ = rsw_pkg::SLOW_RC_HZ / 1000;

    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] limit;

    always_comb begin
        case (prescale)
            2'b00:   limit = CNT_W'(rsw_pkg::WDT_MS_00 * SLOW_KHZ);
            2'b01:   limit = CNT_W'(rsw_pkg::WDT_MS_01 * SLOW_KHZ);
            2'b10:   limit = CNT_W'(rsw_pkg::WDT_MS_10 * SLOW_KHZ);
            default: limit = CNT_W'(rsw_pkg::WDT_MS_11 * SLOW_KHZ);
        endcase
    end

    // counts on slow ticks only, so the system clock choice never changes the period
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            count_r  <= '0;
            overflow <= 1'b0;
        end else if (sys_rst || clear) begin
            count_r  <= '0;
            overflow <= 1'b0;
        end else if (run && slow_tick) begin
            if (count_r >= limit - CNT_W'(1)) begin
                count_r  <= '0;
                overflow <= 1'b1;
            end else begin
                count_r  <= count_r + CNT_W'(1);
                overflow <= 1'b0;
            end
        end else begin
            overflow <= 1'b0;
        end
    end
endmodule : rsw_wdt

/* File: sim/rsw_top_props.sv */
// rsw_top_props: port assertions for rsw_top.
// assumes it is bound into every rsw_top.
`timescale 1ns/1ps
module rsw_top_props (
    input wire logic                  core_clk,   // clock
    input wire logic                  reset,      // reset
    input wire rsw_pkg::rsw_sfr_req_s sfr_req,    // access
    input wire rsw_pkg::rsw_mode_e    op_mode,    // mode
    input wire logic                  rom_rd,     // rom strobe
    input wire rsw_pkg::rsw_analog_s  analog_ctl, // analogue
    input wire logic                  sys_rst     // chip reset
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (reset);
    // writes during chip reset are dropped, so only these count
    wire w = sfr_req.wr && !sys_rst;
    wire [7:0] a = sfr_req.addr;
    wire [7:0] d = sfr_req.wdata;
    a_key_reset: assert property (w && a == 8'h97 && d == 8'h56 |-> ##[1:3] sys_rst)
        else $error("no chip reset after key");
    a_rsel_write: assert property (w && a == 8'he3 |=>
        analog_ctl.reset_threshold_sel == $past(d[3:0])) else $error("reset level");
    a_vr_off: assert property (w && a == 8'he3 && d[4] |=> !analog_ctl.vreset_on)
        else $error("voltage reset on");
    a_por_off: assert property (w && a == 8'he3 && d[5]
        && op_mode == rsw_pkg::RSW_MODE_FAST ##1 op_mode == rsw_pkg::RSW_MODE_FAST
        |-> !analog_ctl.powerup_reset_on) else $error("por on");
    a_dsel_write: assert property (w && a == 8'hbf |=>
        analog_ctl.detect_threshold_sel == $past(d[3:0])) else $error("detect level");
    a_det_sleep: assert property (op_mode inside {rsw_pkg::RSW_MODE_IDLE,
        rsw_pkg::RSW_MODE_HALT, rsw_pkg::RSW_MODE_STOP} |-> !analog_ctl.detector_on)
        else $error("detector awake");
    a_rst_default: assert property (sys_rst && $past(sys_rst) |->
        analog_ctl.reset_threshold_sel == 4'h0) else $error("no default");
    a_rom_in_rst: assert property (rom_rd |-> sys_rst) else $error("late rom load");
    cover property (rom_rd ##1 !rom_rd);
    cover property (w && a == 8'h97);
    cover property (op_mode == rsw_pkg::RSW_MODE_IDLE);
endmodule : rsw_top_props
bind rsw_top rsw_top_props u_props (.core_clk(core_clk), .reset(reset), .sfr_req(sfr_req),
    .op_mode(op_mode), .rom_rd(rom_rd), .analog_ctl(analog_ctl), .sys_rst(sys_rst));

/* File: sim/rsw_top_tb.sv */
// rsw_top_tb: directed bench for the reset supervisor.
// assumes the checker binds itself; warm-up shortened to 100 cycles.
`timescale 1ns/1ps
module rsw_top_tb;
    logic core_clk, reset, ext_rst_n, detect_cmp, vreset_cmp, rom_rd, sfr_hit, sys_rst;
    logic [7:0] sfr_rdata, rom_data, config_word_high;
    logic [13:0] rom_addr;
    rsw_pkg::rsw_sfr_req_s sfr_req;
    rsw_pkg::rsw_mode_e op_mode;
    rsw_pkg::rsw_analog_s analog_ctl;
    int errors, n_tests;
    rsw_top #(.WARMUP_CYCLES(100)) dut_u (.core_clk(core_clk), .reset(reset), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .op_mode(op_mode), .ext_rst_n(ext_rst_n),
        .detect_cmp(detect_cmp), .vreset_cmp(vreset_cmp), .rom_addr(rom_addr), .rom_rd(rom_rd),
        .rom_data(rom_data), .analog_ctl(analog_ctl), .sys_rst(sys_rst),
        .config_word_high(config_word_high));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // last config byte: pin reset on, detect level 1111
    always @(posedge core_clk) rom_data <= (rom_addr[2:0] == 3'h7) ? 8'h9e : 8'h00;
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [7:0] d);
        sfr_req <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk);
        sfr_req <= '{1'b0, 1'b0, a, d};
        @(posedge core_clk);
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] e);
        sfr_req <= '{1'b0, 1'b1, a, 8'h00};
        @(negedge core_clk);
        chk($sformatf("reg %h", a), e, sfr_rdata);
        chk("hit", {7'h0, a != 8'h90}, {7'h0, sfr_hit});
        @(posedge core_clk);
    endtask : rd
    task automatic ck_an(logic [7:0] e);
        @(negedge core_clk);
        chk("analog", e, {analog_ctl.detector_on, 1'b0, analog_ctl.vreset_on,
            analog_ctl.powerup_reset_on, analog_ctl.reset_threshold_sel});
        @(posedge core_clk);
    endtask : ck_an
    task automatic wait_rst(logic v);
        for (int i = 0; i < 9000 && sys_rst !== v; i++) @(negedge core_clk);
        chk("sys_rst", {7'h0, v}, {7'h0, sys_rst});
        if (sys_rst !== v) stop_test();
        @(posedge core_clk);
    endtask : wait_rst
    task automatic stop_test();
        $display("errors %0d tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    task automatic t_volt();
        wr(8'he3, 8'h3a);
        ck_an(8'h8a);
        wr(8'he3, 8'h40);
        wr(8'hf7, 8'h20);
        op_mode <= rsw_pkg::RSW_MODE_IDLE;
        ck_an(8'h10);
        op_mode <= rsw_pkg::RSW_MODE_HALT;
        ck_an(8'h00);
        op_mode <= rsw_pkg::RSW_MODE_STOP;
        wr(8'he3, 8'h00);
        ck_an(8'h10);
        op_mode <= rsw_pkg::RSW_MODE_SLOW;
        wr(8'hf8, 8'ha8);
        rd(8'hf8, 8'h28);
    endtask : t_volt
    task automatic t_detect();
        wr(8'hbf, 8'h80);
        rd(8'h95, 8'h80);
        wr(8'hbf, 8'h00);
        wr(8'h95, 8'h7f);
        rd(8'h95, 8'h00);
        detect_cmp <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(8'hbf, 8'h40);
        rd(8'h95, 8'h80);
        detect_cmp <= 1'b0;
    endtask : t_detect
    initial begin
        {reset, ext_rst_n, detect_cmp, vreset_cmp} = 4'b1100;
        sfr_req = '0;
        op_mode = rsw_pkg::RSW_MODE_FAST;
        errors = 0;
        n_tests = 0;
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        wait_rst(1'b0);
        chk("cfg", 8'h9e, config_word_high);
        rd(8'he3, 8'h40);
        rd(8'hbf, 8'h0f);
        rd(8'h90, 8'h00);
        t_volt();
        t_detect();
        wr(8'h97, 8'h55);
        ck_an(8'hb0);
        rd(8'he3, 8'h00);
        wr(8'h97, 8'h56);
        wait_rst(1'b1);
        wait_rst(1'b0);
        rd(8'he3, 8'h40);
        ext_rst_n <= 1'b0;
        wait_rst(1'b1);
        ext_rst_n <= 1'b1;
        wait_rst(1'b0);
        // low supply with the voltage reset powered down must not reset the chip
        wr(8'he3, 8'h10);
        vreset_cmp <= 1'b1;
        repeat (8) @(negedge core_clk);
        chk("sys_rst", 8'h00, {7'h0, sys_rst});
        @(posedge core_clk);
        wr(8'he3, 8'h00);
        wait_rst(1'b1);
        vreset_cmp <= 1'b0;
        wait_rst(1'b0);
        stop_test();
    end
endmodule : rsw_top_tb
